// >>> logic/dpm_pin_mux.sv
// Purpose: multifunction pin control with two live probe outputs
// Assumes: pads and the fuse sense arrive asynchronously; nodes are core-clocked
// Notes:   pads are split into input, output and active-low output enable
`timescale 1ns/1ps

module dpm_pin_mux
  import dpm_pkg::*;
#(
  parameter int unsigned NUM_IO = 8,
  parameter int unsigned SEL_W  = 8
)
(
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  rstn_in,
  // mode pin
  input  wire logic                  mode_pin_in,
  // pads
  input  wire logic [NUM_IO-1:0]     pad_in,
  output logic      [NUM_IO-1:0]     pad_out,
  output logic      [NUM_IO-1:0]     pad_oe_n_out,
  // user i/o configuration
  input  wire logic [NUM_IO-1:0]     io_used_in,
  input  wire logic [2*NUM_IO-1:0]   io_mode_in,
  input  wire logic                  gclk_as_clock_in,
  // core side of the user i/o
  input  wire logic [NUM_IO-1:0]     core_out_in,
  input  wire logic [NUM_IO-1:0]     core_oe_in,
  output logic      [NUM_IO-1:0]     core_in_out,
  // buffered global clock
  output logic                       gclk_buf_out,
  // observable internal nodes
  input  wire logic [(1<<SEL_W)-1:0] probe_nodes_in,
  // permanent probe disable
  input  wire logic                  fuse_sense_in,
  output logic                       fuse_burn_out,
  output logic                       probe_locked_out,
  // programming data
  output logic      [DPM_DATA_W-1:0] prog_data_out,
  output logic                       prog_valid_out,
  // status
  output logic                       special_mode_out
);

  // synchronisers
  logic [NUM_IO-1:0]      pad_s1_r;
  logic [NUM_IO-1:0]      pad_s2_r;
  logic                   mode_s1_r;
  logic                   mode_s2_r;
  logic                   fuse_s1_r;
  logic                   fuse_s2_r;
  logic                   diag_clock_d_r;

  // serial front end
  dpm_state_t             state_r;
  dpm_state_t             state_nxt;
  logic [3:0]             cnt_r;
  logic [3:0]             cnt_nxt;
  logic [DPM_FRAME_W-1:0] shift_r;
  logic [DPM_FRAME_W-1:0] shift_nxt;

  // probe selection, disable and programming data
  logic [SEL_W-1:0]       sel_a_r;
  logic [SEL_W-1:0]       sel_b_r;
  logic                   burn_r;
  logic [DPM_DATA_W-1:0]  prog_data_r;
  logic                   prog_valid_r;

  // pad and status output flops
  logic [NUM_IO-1:0]      pad_out_r;
  logic [NUM_IO-1:0]      pad_oe_n_r;
  logic [NUM_IO-1:0]      core_in_r;
  logic                   gclk_buf_r;
  logic                   locked_r;
  logic                   special_r;

  // decode
  wire                    mode_s    = mode_s2_r;
  wire                    clock_rise = pad_s2_r[DPM_CH_DIAG_CLOCK] & ~diag_clock_d_r;
  wire                    serial_bit = pad_s2_r[DPM_CH_SERIAL_IN];
  wire                    exec      = (state_r == DPM_ST_EXEC);
  wire [DPM_OPC_W-1:0]    opc       = shift_r[DPM_FRAME_W-1 -: DPM_OPC_W];
  wire [DPM_DATA_W-1:0]   dat       = shift_r[DPM_DATA_W-1:0];
  wire                    locked    = fuse_s2_r | burn_r;
  wire                    take_sel_a = exec & (opc == DPM_OPC_SEL_A) & ~locked;
  wire                    take_sel_b = exec & (opc == DPM_OPC_SEL_B) & ~locked;
  wire                    take_burn = exec & (opc == DPM_OPC_FUSE) & (dat == DPM_FUSE_KEY);
  wire                    take_prog = exec & (opc == DPM_OPC_PROG);
  wire                    probe_a   = probe_nodes_in[sel_a_r];
  wire                    probe_b   = probe_nodes_in[sel_b_r];
  wire [SEL_W-1:0]        dat_sel   = SEL_W'(dat);

  // per-channel next values
  logic [NUM_IO-1:0]      pad_out_nxt;
  logic [NUM_IO-1:0]      pad_oe_n_nxt;
  logic [NUM_IO-1:0]      core_in_nxt;

  // serial frame sequencing
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    case (state_r)
      DPM_ST_USER:
      begin
        cnt_nxt = DPM_CNT_RST;
        if (mode_s)
          state_nxt = DPM_ST_SHIFT;                            // [R1]
      end
      DPM_ST_SHIFT:
      begin
        if (!mode_s)
        begin
          state_nxt = DPM_ST_USER;                             // [R2]
          cnt_nxt   = DPM_CNT_RST;
        end
        else if (clock_rise)                                   // [R3]
        begin
          shift_nxt = {shift_r[DPM_FRAME_W-2:0], serial_bit};  // [R4]
          if (cnt_r == DPM_FRAME_END)
          begin
            state_nxt = DPM_ST_EXEC;
            cnt_nxt   = DPM_CNT_RST;
          end
          else
            cnt_nxt = cnt_r + 4'h1;
        end
      end
      DPM_ST_EXEC:
      begin
        cnt_nxt   = DPM_CNT_RST;
        state_nxt = mode_s ? DPM_ST_SHIFT : DPM_ST_USER;
      end
      default:
      begin
        state_nxt = DPM_ST_USER;
        cnt_nxt   = DPM_CNT_RST;
      end
    endcase
  end

  // pad muxing, one slice per channel
  genvar i;
  generate
    for (i = 0; i < NUM_IO; i = i + 1)
    begin : g_ch
      wire [1:0] m        = io_mode_in[2*i +: 2];
      wire       used     = io_used_in[i];
      wire       is_in    = (m == DPM_IOM_INPUT);
      wire       is_out   = (m == DPM_IOM_OUTPUT);
      wire       rd_en    = (m == DPM_IOM_INPUT) | (m == DPM_IOM_BIDIR);
      wire       usr_out  = used & ~is_in & core_out_in[i];              // [R11]
      wire       usr_oe_n = used & (is_in | (~is_out & ~core_oe_in[i])); // [R10]
      wire       usr_cin  = used & rd_en & pad_s2_r[i];                  // [R10]
      if (i == DPM_CH_DIAG_CLOCK || i == DPM_CH_SERIAL_IN)
      begin : g_diag_in
        assign pad_out_nxt[i]  = mode_s ? 1'b0 : usr_out;                // [R1]
        assign pad_oe_n_nxt[i] = mode_s ? 1'b1 : usr_oe_n;               // [R2]
        assign core_in_nxt[i]  = mode_s ? 1'b0 : usr_cin;
      end
      else if (i == DPM_CH_PROBE_A || i == DPM_CH_PROBE_B)
      begin : g_probe
        wire node = (i == DPM_CH_PROBE_A) ? probe_a : probe_b;           // [R5] [R6]
        assign pad_out_nxt[i]  = mode_s ? (node & ~locked) : usr_out;    // [R12] [R7]
        assign pad_oe_n_nxt[i] = mode_s ? 1'b0 : usr_oe_n;               // [R7]
        assign core_in_nxt[i]  = mode_s ? 1'b0 : usr_cin;
      end
      else if (i == DPM_CH_GCLK)
      begin : g_gclk
        assign pad_out_nxt[i]  = gclk_as_clock_in ? 1'b0 : usr_out;      // [R9]
        assign pad_oe_n_nxt[i] = gclk_as_clock_in ? 1'b1 : usr_oe_n;     // [R9]
        assign core_in_nxt[i]  = gclk_as_clock_in ? 1'b0 : usr_cin;
      end
      else
      begin : g_user
        assign pad_out_nxt[i]  = usr_out;
        assign pad_oe_n_nxt[i] = usr_oe_n;
        assign core_in_nxt[i]  = usr_cin;
      end
    end
  endgenerate

  // synchronisers
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pad_s1_r  <= '0;
      pad_s2_r  <= '0;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
      diag_clock_d_r <= 1'b0;
    end
    else
    begin
      pad_s1_r  <= pad_in;
      pad_s2_r  <= pad_s1_r;
      mode_s1_r <= mode_pin_in;
      mode_s2_r <= mode_s1_r;
      fuse_s1_r <= fuse_sense_in;
      fuse_s2_r <= fuse_s1_r;
      diag_clock_d_r <= pad_s2_r[DPM_CH_DIAG_CLOCK];
    end
  end

  // serial front end state
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= DPM_ST_USER;
      cnt_r   <= DPM_CNT_RST;
      shift_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  // probe selection, disable and programming data
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sel_a_r      <= SEL_W'(DPM_SEL_RST);
      sel_b_r      <= SEL_W'(DPM_SEL_RST);
      burn_r       <= 1'b0;
      prog_data_r  <= '0;
      prog_valid_r <= 1'b0;
    end
    else
    begin
      if (take_sel_a)
        sel_a_r <= dat_sel;                                    // [R6]
      if (take_sel_b)
        sel_b_r <= dat_sel;                                    // [R6]
      if (take_burn)
        burn_r <= 1'b1;                                        // [R8]
      if (take_prog)
        prog_data_r <= dat;                                    // [R4]
      prog_valid_r <= take_prog;
    end
  end

  // pad and status output flops
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pad_out_r  <= '0;
      pad_oe_n_r <= '1;
      core_in_r  <= '0;
      gclk_buf_r <= 1'b0;
      locked_r   <= 1'b0;
      special_r  <= 1'b0;
    end
    else
    begin
      pad_out_r  <= pad_out_nxt;
      pad_oe_n_r <= pad_oe_n_nxt;
      core_in_r  <= core_in_nxt;
      gclk_buf_r <= gclk_as_clock_in & pad_s2_r[DPM_CH_GCLK];  // [R9]
      locked_r   <= locked;                                    // [R8]
      special_r  <= mode_s;
    end
  end

  // outputs
  assign pad_out          = pad_out_r;
  assign pad_oe_n_out     = pad_oe_n_r;
  assign core_in_out      = core_in_r;
  assign gclk_buf_out     = gclk_buf_r;
  assign fuse_burn_out    = burn_r;
  assign probe_locked_out = locked_r;
  assign prog_data_out    = prog_data_r;
  assign prog_valid_out   = prog_valid_r;
  assign special_mode_out = special_r;

endmodule // dpm_pin_mux

// >>> logic/dpm_pkg.sv
// Purpose: constants shared by the diagnostic probe pin multiplexer
// Assumes: one core clock, asynchronous active-low reset
// Notes:   channel map, i/o modes and the serial frame layout live here
//
// Overview of operation
// R1 - mode high: all four multifunction pins take their diagnostic functions
// R2 - mode low: the four multifunction pins behave as ordinary user i/o
// R3 - special mode: diag_clock pin times probe selection and programming frames
// R4 - special mode: diag_serial_in carries serial frames from the outside party
// R5 - probe_out_a shows the selected internal node live
// R6 - two probe outputs with separately chosen nodes
// R7 - probe pins return to user i/o once debugging ends
// R8 - a permanent disable stops all further probe observation
// R9 - global clock pin is buffered into the clock net, or is user i/o
// R10 - each user pin is input, output, three-state or bidirectional
// R11 - unused user pins drive a constant low
// R12 - after the permanent disable probe pins never show internal nodes
package dpm_pkg;

  // pad channel map
  localparam int unsigned DPM_CH_DIAG_CLOCK = 0;
  localparam int unsigned DPM_CH_SERIAL_IN  = 1;
  localparam int unsigned DPM_CH_PROBE_A    = 2;
  localparam int unsigned DPM_CH_PROBE_B    = 3;
  localparam int unsigned DPM_CH_GCLK  = 4;
  localparam int unsigned DPM_CH_FIXED = 5;

  // user i/o buffer modes
  localparam logic [1:0] DPM_IOM_INPUT  = 2'h0;
  localparam logic [1:0] DPM_IOM_OUTPUT = 2'h1;
  localparam logic [1:0] DPM_IOM_TRI    = 2'h2;
  localparam logic [1:0] DPM_IOM_BIDIR  = 2'h3;

  // serial frame: opcode then data, msb first
  localparam int unsigned DPM_OPC_W     = 2;
  localparam int unsigned DPM_DATA_W    = 8;
  localparam int unsigned DPM_FRAME_W   = 10;
  localparam logic [3:0]  DPM_FRAME_END = 4'h9;
  localparam logic [3:0]  DPM_CNT_RST   = 4'h0;
  localparam logic [1:0]  DPM_OPC_PROG  = 2'h0;
  localparam logic [1:0]  DPM_OPC_SEL_A = 2'h1;
  localparam logic [1:0]  DPM_OPC_SEL_B = 2'h2;
  localparam logic [1:0]  DPM_OPC_FUSE  = 2'h3;
  localparam logic [7:0]  DPM_FUSE_KEY  = 8'hA5;

  // reset values
  localparam logic [7:0]  DPM_SEL_RST   = 8'h00;

  // serial front end states
  typedef enum logic [2:0] {
    DPM_ST_USER  = 3'b001,
    DPM_ST_SHIFT = 3'b010,
    DPM_ST_EXEC  = 3'b100
  } dpm_state_t;

endpackage

// >>> test/dpm_checker.sv
// Purpose: port assertions for the probe pin multiplexer
// Assumes: bound to dpm_pin_mux, one core clock
// Notes:   pin6 unused, pin7 swept through the buffer modes
`timescale 1ns/1ps
module dpm_checker
  import dpm_pkg::*;
#(
  parameter int unsigned NUM_IO = 8
)
(
  input wire logic                core_clk_in,
  input wire logic                rstn_in,
  input wire logic [NUM_IO-1:0]   pad_out,
  input wire logic [NUM_IO-1:0]   pad_oe_n_out,
  input wire logic [NUM_IO-1:0]   io_used_in,
  input wire logic [2*NUM_IO-1:0] io_mode_in,
  input wire logic [NUM_IO-1:0]   core_out_in,
  input wire logic [NUM_IO-1:0]   core_oe_in,
  input wire logic                fuse_burn_out,
  input wire logic                probe_locked_out,
  input wire logic                prog_valid_out,
  input wire logic                special_mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_unused;
    !io_used_in[6] |=> !pad_oe_n_out[6] && !pad_out[6];
  endproperty
  a_unused: assert property (p_unused) else $error("unused pin not low");
  property p_tri;
    io_used_in[7] && io_mode_in[15] |=> pad_oe_n_out[7] == !$past(core_oe_in[7]);
  endproperty
  a_tri: assert property (p_tri) else $error("three-state enable wrong");
  property p_out;
    io_used_in[7] && io_mode_in[15:14] == DPM_IOM_OUTPUT
      |=> !pad_oe_n_out[7] && pad_out[7] == $past(core_out_in[7]);
  endproperty
  a_out: assert property (p_out) else $error("output pin wrong");
  property p_user;
    io_used_in[2] && io_mode_in[5:4] == DPM_IOM_OUTPUT ##1 !special_mode_out
      |-> !pad_oe_n_out[2] && pad_out[2] == $past(core_out_in[2]);
  endproperty
  a_user: assert property (p_user) else $error("probe pin not user i/o");
  property p_special;
    special_mode_out [*2] |-> pad_oe_n_out[3:0] == 4'h3;
  endproperty
  a_special: assert property (p_special) else $error("special pins wrong");
  property p_locked;
    (special_mode_out && probe_locked_out) [*2] |-> pad_out[3:2] == 2'h0;
  endproperty
  a_locked: assert property (p_locked) else $error("locked probe shows node");
  property p_pulse;
    prog_valid_out |=> !prog_valid_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("programming pulse too long");
  property p_burn;
    fuse_burn_out |=> fuse_burn_out && probe_locked_out;
  endproperty
  a_burn: assert property (p_burn) else $error("disable not held");
endmodule // dpm_checker

// >>> test/dpm_prog_model.sv
// Purpose: outside programmer and nonvolatile disable cell
// Assumes: bits sent msb first, 4 cycles low and 5 high each
// Notes:   clock stands low between frames, data inverts when idle
`timescale 1ns/1ps
module dpm_prog_model
(
  input  wire logic clk_in,
  input  wire logic burn_in,
  output logic      diag_clock_out,
  output logic      serial_out,
  output logic      fuse_out
);
  initial
  begin
    diag_clock_out = 1'b0;
    serial_out     = 1'b0;
    fuse_out = 1'b0;
  end
  // cell keeps its state across resets
  always @(posedge clk_in)
    if (burn_in)
      fuse_out <= 1'b1;
  task automatic send(input logic [9:0] f);
    for (int i = 9; i >= 0; i--)
    begin
      @(posedge clk_in);
      serial_out     <= f[i];
      diag_clock_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      diag_clock_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    @(posedge clk_in);
    diag_clock_out <= 1'b0;
    serial_out     <= ~serial_out;
  endtask
endmodule // dpm_prog_model

// >>> test/testbench.sv
// Purpose: self-checking bench for the probe pin multiplexer
// Assumes: default NUM_IO and SEL_W, pads resolved from enables
// Notes:   the model's cell survives the mid-run reset
`timescale 1ns/1ps
module testbench;
  import dpm_pkg::*;
  logic         core_clk_in, rstn_in, mode_pin_in, gclk_as_clock_in, fuse_sense_in;
  logic [7:0]   io_used_in, core_out_in, core_oe_in, drv, pad_out, pad_oe_n_out;
  logic [7:0]   core_in_out, prog_data_out;
  logic [15:0]  io_mode_in;
  logic [255:0] probe_nodes_in;
  logic         gclk_buf_out, fuse_burn_out, probe_locked_out, prog_valid_out;
  logic         special_mode_out, diag_clock, diag_serial;
  int           num_errors, tests_run, n_valid;
  wire logic [7:0] pad_in = (pad_oe_n_out & {drv[7:2], diag_serial, diag_clock})
                          | (~pad_oe_n_out & pad_out);
  dpm_pin_mux i_dpm_pin_mux(.*);
  dpm_prog_model i_dpm_prog_model(.clk_in(core_clk_in), .burn_in(fuse_burn_out),
    .diag_clock_out(diag_clock), .serial_out(diag_serial), .fuse_out(fuse_sense_in));
  always @(posedge core_clk_in)
    if (prog_valid_out)
      n_valid <= n_valid + 1;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_user();
    drv[5] <= 1'b1;
    drv[4] <= 1'b1;
    core_out_in[2] <= 1'b1;
    tick(5);
    check("unused pin", {pad_oe_n_out[6], pad_out[6]}, 8'h0);
    check("user pin", {pad_oe_n_out[2], pad_out[2]}, 8'h1);
    check("input pin", core_in_out[5], 8'h1);
    check("gclk buffer", gclk_buf_out, 8'h1);
  endtask
  task automatic t_modes();
    logic [1:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:1];
      io_mode_in[15:14] <= m;
      core_oe_in[7] <= i[0];
      tick(2);
      check("mode oe_n", pad_oe_n_out[7], 8'((m == DPM_IOM_INPUT) || (m[1] && !i[0])));
    end
  endtask
  task automatic t_probe();
    mode_pin_in <= 1'b1;
    tick(6);
    check("special oe_n", pad_oe_n_out[3:0], 8'h3);
    check("special mode", special_mode_out, 8'h1);
    i_dpm_prog_model.send({DPM_OPC_SEL_A, 8'h25});
    i_dpm_prog_model.send({DPM_OPC_SEL_B, 8'hC8});
    for (int v = 0; v < 2; v++)
    begin
      probe_nodes_in[8'h25] <= v[0];
      probe_nodes_in[8'hC8] <= !v[0];
      tick(2);
      check("probe pins", pad_out[3:2], v ? 8'h1 : 8'h2);
    end
    i_dpm_prog_model.send({DPM_OPC_PROG, 8'h5C});
    tick(4);
    check("prog count", 8'(n_valid), 8'h1);
    check("prog data", prog_data_out, 8'h5C);
  endtask
  task automatic t_fuse();
    probe_nodes_in <= '1;
    i_dpm_prog_model.send({DPM_OPC_FUSE, 8'h5A});
    tick(4);
    check("wrong key", {fuse_burn_out, probe_locked_out, pad_out[3:2]}, 8'h3);
    i_dpm_prog_model.send({DPM_OPC_FUSE, DPM_FUSE_KEY});
    tick(4);
    check("locked", {fuse_burn_out, probe_locked_out, pad_out[3:2]}, 8'hC);
    rstn_in <= 1'b0;
    tick(2);
    rstn_in <= 1'b1;
    tick(8);
    check("relocked", {fuse_burn_out, probe_locked_out, pad_out[3:2]}, 8'h4);
    mode_pin_in <= 1'b0;
    core_out_in[3:2] <= 2'h2;
    tick(5);
    check("probe reuse", pad_out[3:2], 8'h2);
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    rstn_in = 1'b0;
    mode_pin_in = 1'b0;
    gclk_as_clock_in = 1'b1;
    drv = 8'h00;
    io_used_in = 8'hBF;
    io_mode_in = 16'h8050;
    core_out_in = 8'h00;
    core_oe_in = 8'h00;
    probe_nodes_in = '0;
    num_errors = 0;
    tests_run = 0;
    n_valid = 0;
    tick(8);
    rstn_in <= 1'b1;
    t_user();
    t_modes();
    t_probe();
    t_fuse();
    complete_run();
  end
endmodule // testbench
bind dpm_pin_mux dpm_checker #(.NUM_IO(NUM_IO)) i_dpm_checker(.*);
